// *** fpes_flash_model.sv ***
// Purpose: behavioural parallel flash facing the host
// Assumes: 16 words, four blocks of four
// Notes: busy count ticks every 10 ns
`timescale 1ns/1ps
module fpes_flash_model
	import fpes_pkg::*;
(
	input  wire fpes_pins_s         pins,
	input  wire logic               reset_powerdown_n,
	input  wire logic [FPES_DW-1:0] dq_out,
	input  wire logic               vpp_ok,
	output logic [FPES_DW-1:0]      dq_in
);
	logic [15:0] mem [16];
	logic [15:0] ld;
	logic [21:0] la;
	logic [7:0]  setup, err, cmd;
	logic [3:0]  lk;
	logic        st, susp;
	int          cnt;
	wire  [7:0]  srv = {cnt == 0 || susp, 1'b0, err[5:3], susp, err[1], 1'b0};
	wire  [15:0] rd  = st ? {8'h00, srv} : mem[pins.addr[3:0]];
	// array is nonvolatile: erased at power-up and by block erase, never by reset
	initial foreach (mem[i]) mem[i] = 16'hffff;
	// released bus shows the inverse
	assign dq_in = (!pins.ce_n && !pins.oe_n) ? rd : ~rd;
	always @(*) if (!pins.we_n) begin
		la = pins.addr;
		ld = dq_out;
	end
	always #10 if (cnt != 0 && !susp) cnt = cnt - 1;
	always @(negedge reset_powerdown_n or posedge pins.we_n) begin
		cmd = ld[7:0];
		if (!reset_powerdown_n) begin
			{st, susp, setup, err, cnt, lk} = '0;
		end else if (setup == FPES_CMD_PROG) begin
			if (lk[la[3:2]]) err[1] = 1'b1;
			else if (!vpp_ok) err[3] = 1'b1;
			else begin
				mem[la[3:0]] = mem[la[3:0]] & ld;
				cnt = 100;
			end
			setup = '0;
		end else if (setup == FPES_CMD_ERASE) begin
			if (cmd != FPES_CMD_CONFIRM) err[5:4] = 2'h3;
			else if (!vpp_ok) err = err | 8'h28;
			else begin
				cnt = 100;
				for (int i = 0; i < 4; i++) mem[{la[3:2], i[1:0]}] = 16'hffff;
			end
			setup = '0;
		end else if (setup == FPES_CMD_LOCK_SETUP) begin
			lk[la[3:2]] = cmd != FPES_CMD_CONFIRM;
			setup = '0;
		end else if (cmd == FPES_CMD_SUSPEND) susp = cnt != 0;
		else if (cmd == FPES_CMD_CONFIRM) susp = 1'b0;
		else if (cmd == FPES_CMD_READ_STAT) st = 1'b1;
		else if (cnt == 0 || susp) begin
			if (cmd == FPES_CMD_READ_ARRAY) st = 1'b0;
			else if (cmd == FPES_CMD_CLR_STAT) err = '0;
			else begin
				setup = cmd;
				st = 1'b1;
			end
		end
	end
endmodule : fpes_flash_model

// *** fpes_host.sv ***
// Purpose: host-side sequencer issuing command writes and reads to a parallel flash
// Assumes: flash data pins are split in/out/enable; inputs synchronous to sys_clk
// Notes: one request at a time; busy polling is done by the user via status op
`timescale 1ns/1ps
module fpes_host
	import fpes_pkg::*;
(
	input  wire logic                 sys_clk,
	input  wire logic                 arst_n,
	input  wire fpes_req_s            req,
	input  wire logic                 req_valid,
	output logic                      req_ready,
	output logic                      rsp_valid,
	output logic [FPES_DW-1:0]        rsp_data,
	output logic [7:0]                status_read_word,
	output logic                      ready_bit,
	output logic                      error_any,
	output fpes_pins_s                pins,
	output logic                      reset_powerdown_n,
	output logic [FPES_DW-1:0]        dq_out,
	output logic                      dq_oe,
	input  wire logic [FPES_DW-1:0]   dq_in
);
	// ---------------------------------------------------------------
	// states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		FPES_ST_IDLE  = 3'h0,
		FPES_ST_WR1   = 3'h1,
		FPES_ST_GAP   = 3'h2,
		FPES_ST_WR2   = 3'h3,
		FPES_ST_RD    = 3'h4,
		FPES_ST_REST  = 3'h5,
		FPES_ST_DONE  = 3'h6
	} fpes_st_e;

	fpes_st_e           state;
	fpes_st_e           next_state;
	fpes_req_s          cur;
	logic [7:0]         cnt;
	logic               two_write;
	logic               do_read;
	logic [7:0]         first_code;
	logic [FPES_DW-1:0] second_data;
	logic               cnt_done;
	logic               strobe_on;
	logic               in_write;
	logic               in_read;
	logic               next_wr;
	logic               next_rd;
	logic               next_drive;
	logic [FPES_DW-1:0] next_dq;
	logic [7:0]         next_cnt;
	logic               take;
	logic               read_cap;
	logic               status_cap;
	logic               status_err;

	// ---------------------------------------------------------------
	// command decode
	// ---------------------------------------------------------------
	always_comb begin
		first_code  = FPES_CMD_READ_STAT;
		second_data = cur.data;
		two_write   = 1'b0;
		do_read     = 1'b0;
		case (cur.op)
			FPES_OP_PROGRAM: begin
				first_code = FPES_CMD_PROG;
				two_write  = 1'b1;
			end
			FPES_OP_ERASE: begin
				first_code  = FPES_CMD_ERASE;
				second_data = {8'h00, FPES_CMD_CONFIRM};
				two_write   = 1'b1;
			end
			FPES_OP_SUSPEND: first_code = FPES_CMD_SUSPEND;
			FPES_OP_RESUME:  first_code = FPES_CMD_CONFIRM;
			FPES_OP_LOCK: begin
				first_code  = FPES_CMD_LOCK_SETUP;
				second_data = {8'h00, cur.data[7:0]};
				two_write   = 1'b1;
			end
			FPES_OP_CLEAR:   first_code = FPES_CMD_CLR_STAT;
			FPES_OP_READ: begin
				first_code = FPES_CMD_READ_ARRAY;
				do_read    = 1'b1;
			end
			FPES_OP_STATUS: begin
				first_code = FPES_CMD_READ_STAT;
				do_read    = 1'b1;
			end
			default: first_code = FPES_CMD_READ_STAT;
		endcase
	end

	assign cnt_done  = (cnt == 8'(FPES_STROBE_CYC - 1));
	assign in_write  = (state == FPES_ST_WR1) || (state == FPES_ST_WR2);
	assign in_read   = (state == FPES_ST_RD);
	assign strobe_on = in_write || in_read;
	assign req_ready = (state == FPES_ST_IDLE);
	assign take      = req_valid && req_ready;
	assign next_cnt  = (next_state != state) ? 8'h00 : cnt + 8'h01;

	// ---------------------------------------------------------------
	// next pin levels
	// ---------------------------------------------------------------
	assign next_wr    = (next_state == FPES_ST_WR1) || (next_state == FPES_ST_WR2);
	assign next_rd    = (next_state == FPES_ST_RD);
	assign next_drive = next_wr || (next_state == FPES_ST_GAP);
	assign next_dq    = (next_state == FPES_ST_WR2) ? second_data : {8'h00, first_code};

	// ---------------------------------------------------------------
	// capture decode
	// ---------------------------------------------------------------
	assign read_cap   = in_read && cnt_done;
	assign status_cap = read_cap && (cur.op == FPES_OP_STATUS);
	assign status_err = dq_in[FPES_ERASE_FAIL_BIT] | dq_in[FPES_PROG_FAIL_BIT]
	                  | dq_in[FPES_SUPPLY_ERR_BIT] | dq_in[FPES_LOCK_ERR_BIT];

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			FPES_ST_IDLE: if (req_valid) next_state = FPES_ST_WR1;
			FPES_ST_WR1:  if (cnt_done) next_state = FPES_ST_GAP;
			FPES_ST_GAP:  if (cnt_done) next_state = two_write ? FPES_ST_WR2 : (do_read ? FPES_ST_RD : FPES_ST_DONE);
			FPES_ST_WR2:  if (cnt_done) next_state = FPES_ST_REST;
			FPES_ST_RD:   if (cnt_done) next_state = FPES_ST_REST;
			FPES_ST_REST: if (cnt_done) next_state = FPES_ST_DONE;
			FPES_ST_DONE: next_state = FPES_ST_IDLE;
			default:      next_state = FPES_ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= FPES_ST_IDLE;
			cnt   <= 8'h00;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cur <= '0;
		end else if (take) begin
			cur <= req;
		end
	end

	// ---------------------------------------------------------------
	// pins
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			pins              <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0};
			dq_out            <= '0;
			dq_oe             <= 1'b0;
			reset_powerdown_n <= 1'b0;
		end else begin
			reset_powerdown_n <= 1'b1;
			pins.ce_n <= !(next_wr || next_rd);
			pins.we_n <= !next_wr;
			pins.oe_n <= !next_rd;
			pins.addr <= cur.addr;
			dq_oe     <= next_drive;
			dq_out    <= next_dq;
		end
	end

	// ---------------------------------------------------------------
	// read capture
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rsp_valid        <= 1'b0;
			rsp_data         <= '0;
			status_read_word <= 8'h80;
			ready_bit        <= 1'b1;
			error_any        <= 1'b0;
		end else begin
			rsp_valid <= (state == FPES_ST_DONE);
			if (read_cap) begin
				rsp_data <= dq_in;
			end
			if (status_cap) begin
				status_read_word <= dq_in[7:0];
				ready_bit        <= dq_in[FPES_READY_BIT];
				error_any        <= status_err;
			end
		end
	end
endmodule : fpes_host

// *** fpes_host_chk.sv ***
// Purpose: port checks for fpes_host
// Assumes: strobe phases of 18 cycles
// Notes: bound to every fpes_host
`timescale 1ns/1ps
module fpes_host_chk
	import fpes_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       arst_n,
	input wire logic       req_valid,
	input wire logic       req_ready,
	input wire logic       rsp_valid,
	input wire logic [7:0] status_read_word,
	input wire logic       ready_bit,
	input wire logic       error_any,
	input wire fpes_pins_s pins,
	input wire logic       reset_powerdown_n,
	input wire logic       dq_oe
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	a_ready_back: assert property (rsp_valid |-> req_ready) else $error("not ready at response");
	a_rp_release: assert property ($past(arst_n) |-> reset_powerdown_n) else $error("device held");
	a_take_write: assert property (req_valid && req_ready |=> !pins.we_n && !pins.ce_n && dq_oe)
		else $error("no write after take");
	a_we_width: assert property ($fell(pins.we_n) |-> ##17 !pins.we_n ##1 pins.we_n) else $error("write width");
	a_oe_toggle: assert property ($fell(pins.oe_n) |-> ##17 !pins.oe_n ##1 pins.oe_n) else $error("read width");
	a_read_free: assert property (!pins.oe_n |-> pins.we_n && !dq_oe) else $error("bus clash");
	a_rsp_time: assert property (req_valid && req_ready |-> ##[37:75] rsp_valid) else $error("late response");
	a_err_sum: assert property (error_any == (|(status_read_word & 8'h3a))) else $error("error sum");
	a_ready_copy: assert property (ready_bit == status_read_word[7]) else $error("ready copy");
	c_err: cover property (rsp_valid && error_any);
	c_busy: cover property (rsp_valid && !ready_bit);
	c_read: cover property ($fell(pins.oe_n));
endmodule : fpes_host_chk
bind fpes_host fpes_host_chk chk_i (.sys_clk, .arst_n, .req_valid, .req_ready, .rsp_valid, .status_read_word,
	.ready_bit, .error_any, .pins, .reset_powerdown_n, .dq_oe);

// *** fpes_host_test.sv ***
// Purpose: sequence test of fpes_host with a flash model
// Assumes: one request at a time
// Notes: ops drive 1 ns after the clock edge
`timescale 1ns/1ps
module fpes_host_test;
	import fpes_pkg::*;
	logic sys_clk = 0, arst_n = 0, req_valid = 0, vpp_ok = 1;
	logic req_ready, rsp_valid, ready_bit, error_any, reset_powerdown_n, dq_oe;
	logic [15:0] rsp_data, dq_out, dq_in;
	logic [7:0]  status_read_word;
	fpes_req_s   req = '0;
	fpes_pins_s  pins;
	int          error_cnt = 0, tests_run = 0, cyc = 0;
	fpes_host dut (.sys_clk, .arst_n, .req, .req_valid, .req_ready, .rsp_valid, .rsp_data, .status_read_word,
		.ready_bit, .error_any, .pins, .reset_powerdown_n, .dq_out, .dq_oe, .dq_in);
	fpes_flash_model flash (.pins, .reset_powerdown_n, .dq_out, .vpp_ok, .dq_in);
	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (++cyc == 20000) begin
		error_cnt++;
		stop_test();
	end
	task chk(logic [15:0] g, logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task op(fpes_op_e o, logic [21:0] a, logic [15:0] d);
		int n;
		n = 0;
		req = '{o, a, d};
		req_valid = 1;
		while (req_ready !== 1'b1) @(posedge sys_clk) #1;
		@(posedge sys_clk) #1 req_valid = 0;
		while (rsp_valid !== 1'b1 && n++ < 100) @(posedge sys_clk) #1;
		chk(n < 100, 1);
	endtask : op
	task poll;
		op(FPES_OP_STATUS, 0, 0);
		repeat (30) if (ready_bit !== 1'b1) op(FPES_OP_STATUS, 0, 0);
	endtask : poll
	task stop_test;
		$display("mismatches %0d of %0d checks", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : stop_test
	initial begin
		repeat (4) @(posedge sys_clk);
		#1 arst_n = 1;
		chk(status_read_word, 8'h80);
		op(FPES_OP_PROGRAM, 22'h5, 16'h00f0);
		op(FPES_OP_STATUS, 0, 0);
		chk(ready_bit, 0);
		poll;
		op(FPES_OP_PROGRAM, 22'h5, 16'hff0f);
		poll;
		chk(status_read_word, 8'h80);
		op(FPES_OP_READ, 22'h5, 0);
		chk(rsp_data, 16'h0000);
		op(FPES_OP_PROGRAM, 22'h6, 16'h1234);
		op(FPES_OP_SUSPEND, 0, 0);
		op(FPES_OP_STATUS, 0, 0);
		chk(status_read_word, 8'h84);
		op(FPES_OP_READ, 22'h5, 0);
		chk(rsp_data, 16'h0000);
		op(FPES_OP_RESUME, 0, 0);
		op(FPES_OP_STATUS, 0, 0);
		chk(ready_bit, 0);
		poll;
		op(FPES_OP_READ, 22'h6, 0);
		chk(rsp_data, 16'h1234);
		vpp_ok = 0;
		op(FPES_OP_ERASE, 22'h8, 0);
		op(FPES_OP_STATUS, 0, 0);
		chk(status_read_word, 8'ha8);
		vpp_ok = 1;
		op(FPES_OP_CLEAR, 0, 0);
		op(FPES_OP_STATUS, 0, 0);
		chk(status_read_word, 8'h80);
		op(FPES_OP_LOCK, 22'h4, 16'h0001);
		op(FPES_OP_PROGRAM, 22'h5, 16'h0000);
		op(FPES_OP_STATUS, 0, 0);
		chk({error_any, status_read_word}, 9'h182);
		op(FPES_OP_CLEAR, 0, 0);
		op(FPES_OP_LOCK, 22'h4, 16'h00d0);
		op(FPES_OP_PROGRAM, 22'h7, 16'h00ff);
		poll;
		chk(status_read_word, 8'h80);
		op(FPES_OP_PROGRAM, 22'h9, 16'h1234);
		poll;
		op(FPES_OP_ERASE, 22'h8, 0);
		op(FPES_OP_STATUS, 0, 0);
		chk(ready_bit, 0);
		poll;
		op(FPES_OP_READ, 22'h9, 0);
		chk(rsp_data, 16'hffff);
		vpp_ok = 0;
		op(FPES_OP_PROGRAM, 22'h7, 16'h0000);
		op(FPES_OP_STATUS, 0, 0);
		chk(status_read_word, 8'h88);
		vpp_ok = 1;
		arst_n = 0;
		repeat (4) @(posedge sys_clk);
		#1 arst_n = 1;
		chk(status_read_word, 8'h80);
		@(posedge sys_clk) #1 chk(reset_powerdown_n, 1);
		op(FPES_OP_STATUS, 0, 0);
		chk(status_read_word, 8'h80);
		op(FPES_OP_READ, 22'h7, 0);
		chk(rsp_data, 16'h00ff);
		stop_test();
	end
endmodule : fpes_host_test

// *** fpes_pkg.sv ***
// Purpose: constants and types for the flash program/erase host controller
// Assumes: x16 parallel flash with command codes on the low data byte
// Notes: timing counts are in sys_clk cycles at 250 MHz
package fpes_pkg;
	localparam logic [7:0] FPES_CMD_READ_ARRAY = 8'hff;
	localparam logic [7:0] FPES_CMD_READ_ID    = 8'h90;
	localparam logic [7:0] FPES_CMD_QUERY      = 8'h98;
	localparam logic [7:0] FPES_CMD_READ_STAT  = 8'h70;
	localparam logic [7:0] FPES_CMD_CLR_STAT   = 8'h50;
	localparam logic [7:0] FPES_CMD_PROG       = 8'h40;
	localparam logic [7:0] FPES_CMD_PROG_ALT   = 8'h10;
	localparam logic [7:0] FPES_CMD_ERASE      = 8'h20;
	localparam logic [7:0] FPES_CMD_CONFIRM    = 8'hd0;
	localparam logic [7:0] FPES_CMD_SUSPEND    = 8'hb0;
	localparam logic [7:0] FPES_CMD_LOCK_SETUP = 8'h60;
	localparam logic [7:0] FPES_CMD_LOCK       = 8'h01;
	localparam logic [7:0] FPES_CMD_LOCKDOWN   = 8'h2f;
	localparam int FPES_READY_BIT      = 7;
	localparam int FPES_ERASE_SUSP_BIT = 6;
	localparam int FPES_ERASE_FAIL_BIT = 5;
	localparam int FPES_PROG_FAIL_BIT  = 4;
	localparam int FPES_SUPPLY_ERR_BIT = 3;
	localparam int FPES_PROG_SUSP_BIT  = 2;
	localparam int FPES_LOCK_ERR_BIT   = 1;
	localparam int FPES_CLK_MHZ        = 250;
	localparam int FPES_STROBE_NS      = 70;
	localparam int FPES_STROBE_CYC     = (FPES_STROBE_NS * FPES_CLK_MHZ + 999) / 1000;
	localparam int FPES_AW             = 22;
	localparam int FPES_DW             = 16;

	typedef enum logic [2:0] {
		FPES_OP_PROGRAM  = 3'h0,
		FPES_OP_ERASE    = 3'h1,
		FPES_OP_SUSPEND  = 3'h2,
		FPES_OP_RESUME   = 3'h3,
		FPES_OP_LOCK     = 3'h4,
		FPES_OP_CLEAR    = 3'h5,
		FPES_OP_READ     = 3'h6,
		FPES_OP_STATUS   = 3'h7
	} fpes_op_e;

	typedef struct packed {
		fpes_op_e              op;
		logic [FPES_AW-1:0]    addr;
		logic [FPES_DW-1:0]    data;
	} fpes_req_s;

	typedef struct packed {
		logic                  ce_n;
		logic                  oe_n;
		logic                  we_n;
		logic [FPES_AW-1:0]    addr;
	} fpes_pins_s;
endpackage : fpes_pkg
